/* File: sim/pfc_ctrl_chk.sv */
/*
 * pfc_ctrl_chk: flash pin protocol checks for pfc_ctrl.
 * Assumes: default phase of six cycles; bound to every pfc_ctrl.
 */
`timescale 1ns/1ps
module pfc_ctrl_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [17:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic [15:0] fl_dq_oe_n,
    input wire logic        fl_ce_n,
    input wire logic        fl_oe_n,
    input wire logic        fl_we_n,
    input wire logic        fl_byte_n,
    input wire logic        fl_reset_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wr_qual_a: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n)
        else $error("write strobe outside a selected write");
    rd_qual_a: assert property (!fl_oe_n |-> !fl_ce_n && fl_we_n)
        else $error("read strobe outside a selected read");
    rd_release_a: assert property (!fl_oe_n |-> &fl_dq_oe_n[14:0]
        && fl_dq_oe_n[15] == fl_byte_n) else $error("bus driven in read");
    wr_drive_a: assert property (!fl_we_n |-> fl_dq_oe_n[7:0] == 8'h00 &&
        (fl_byte_n ? !fl_dq_oe_n[14:8] : &fl_dq_oe_n[14:8]))
        else $error("wrong data pins driven in write");
    byte_lsb_a: assert property (!fl_byte_n && !fl_ce_n
        |-> !fl_dq_oe_n[15]) else $error("byte address lsb not driven");
    wr_width_a: assert property ($fell(fl_we_n)
        |-> !fl_we_n [*6] ##1 fl_we_n) else $error("write strobe width");
    wr_stable_a: assert property (!fl_we_n && !$past(fl_we_n)
        |-> $stable(fl_addr) && $stable(fl_dq_o) && $stable(fl_byte_n))
        else $error("address or data moved in write strobe");
    setup_a: assert property ($fell(fl_ce_n)
        |-> (fl_we_n && fl_oe_n) [*5]) else $error("setup phase too short");
    idle_float_a: assert property (fl_ce_n |-> &fl_dq_oe_n)
        else $error("bus driven while deselected");
    reset_idle_a: assert property (!fl_reset_n |-> fl_ce_n)
        else $error("cycle run while flash held in reset");
endmodule : pfc_ctrl_chk

bind pfc_ctrl pfc_ctrl_chk pfc_ctrl_chk_inst (
    .ref_clk(ref_clk), .rst(rst), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_byte_n(fl_byte_n), .fl_reset_n(fl_reset_n)
);

/* File: sim/pfc_flash_model.sv */
/*
 * pfc_flash_model: behavioural parallel NOR flash for the bench.
 * Assumes: pins come from pfc_ctrl; ref_clk paces the busy time and samples the strobes.
 */
`timescale 1ns/1ps
module pfc_flash_model #(
    parameter int BUSY_CYC = 300
) (
    input  wire logic        ref_clk,
    input  wire logic [17:0] addr,
    input  wire logic [15:0] ctl_o,
    input  wire logic [15:0] ctl_oe_n,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        byte_n,
    input  wire logic        reset_n,
    output logic [15:0]      dq,
    output logic             ready
);
    logic [7:0]  mem [512];
    logic [8:0]  ba;
    logic [15:0] rd;
    logic [15:0] last = 16'h0000;
    logic [7:0]  pdat = 8'h00;
    logic        we_q = 1'b1;
    logic        oe_q = 1'b1;
    logic        tog = 1'b0;
    logic        drv;
    int          busy = 0;
    int          wcnt = 0;
    initial for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h5A;
    // byte mode takes the address lsb from the top data pin
    assign ba = {addr[7:0], byte_n ? 1'b0 : ctl_o[15]};
    assign drv = reset_n && !ce_n && !oe_n;
    assign ready = (busy == 0);
    // released pins show the inverse of the last value, never a stale one
    always_comb begin
        rd = {mem[{addr[7:0], 1'b1}], mem[ba]};
        if (busy > 0)
            rd = {8'h00, ~pdat[7], tog, 6'h00};
        for (int i = 0; i < 16; i++)
            dq[i] = !ctl_oe_n[i] ? ctl_o[i] :
                (drv && (byte_n || i < 8)) ? rd[i] : ~last[i];
    end
    // writes land at the rising write strobe; every fourth one programs
    always @(posedge ref_clk) begin
        last <= dq;
        we_q <= we_n;
        oe_q <= oe_n;
        if (!reset_n) begin
            busy <= 0;
            wcnt <= 0;
        end else begin
            if (busy > 0)
                busy <= busy - 1;
            if (busy > 0 && !oe_q && oe_n && !ce_n)
                tog <= !tog;
            if (!we_q && we_n && !ce_n && oe_n && busy == 0) begin
                wcnt <= (wcnt == 3) ? 0 : wcnt + 1;
                if (wcnt == 3) begin
                    mem[ba] <= ctl_o[7:0];
                    if (byte_n)
                        mem[ba | 9'h001] <= ctl_o[15:8];
                    pdat <= ctl_o[7:0];
                    busy <= BUSY_CYC;
                end
            end
        end
    end
endmodule : pfc_flash_model

/* File: sim/testbench.sv */
/*
 * testbench: drives pfc_ctrl over AXI4-Lite against pfc_flash_model.
 * Assumes: default phase timing; the model stands in for the flash.
 */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [4:0]  c;
        logic [18:0] a;
        logic [15:0] d;
        logic [15:0] e;
        logic [15:0] m;
    } pfc_row_type;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  awaddr = 5'h00;
    logic [4:0]  araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, v, v2;
    logic [17:0] fl_addr;
    logic [15:0] dq_o, dq_oe_n, dq;
    logic        ce_n, oe_n, we_n, byte_n, reset_n, hv, ready;
    int          failures = 0;
    int          check_count = 0;
    // word read, byte reads, then a four-write program and a busy read
    pfc_row_type rows [8] = '{
        '{5'h0D, 19'h3, 16'h0, 16'h5D5C, 16'hFFFF},
        '{5'h09, 19'h7, 16'h0, 16'h005D, 16'h00FF},
        '{5'h09, 19'h6, 16'h0, 16'h005C, 16'h00FF},
        '{5'h0F, 19'h555, 16'h00AA, 16'h0, 16'h0},
        '{5'h0F, 19'h2AA, 16'h0055, 16'h0, 16'h0},
        '{5'h0F, 19'h555, 16'h00A0, 16'h0, 16'h0},
        '{5'h0F, 19'h40, 16'h1234, 16'h0, 16'h0},
        '{5'h0D, 19'h40, 16'h0, 16'h0080, 16'h0080}};
    pfc_ctrl pfc_ctrl_inst (
        .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fl_addr(fl_addr), .fl_dq_o(dq_o),
        .fl_dq_oe_n(dq_oe_n), .fl_dq_i(dq), .fl_ce_n(ce_n),
        .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_byte_n(byte_n),
        .fl_reset_n(reset_n), .fl_reset_hv(hv), .op_done_flag(ready));
    pfc_flash_model pfc_flash_model_inst (
        .ref_clk(ref_clk), .addr(fl_addr), .ctl_o(dq_o),
        .ctl_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .byte_n(byte_n), .reset_n(reset_n), .dq(dq), .ready(ready));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // ready is looked at mid-cycle so the edge that takes it is known
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      output logic [1:0] rs);
        logic aw, w, b;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            aw = awready & awvalid;
            w = wready & wvalid;
            b = bvalid;
            rs = bresp;
            @(posedge ref_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
        // one idle edge, so a following call never re-raises in this step
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        logic ak, rv;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ak = arready & arvalid;
            rv = rvalid;
            d = rdata;
            @(posedge ref_clk);
            if (ak) arvalid <= 1'b0;
        end while (!rv);
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    // one flash bus cycle: address, data, command, then poll until idle
    task automatic op(input logic [4:0] c, input logic [18:0] a,
                      input logic [15:0] d, output logic [31:0] o);
        int n;
        wr(pfc_pkg::OFF_ADDR, {13'h0, a}, r);
        wr(pfc_pkg::OFF_WDATA, {16'h0, d}, r);
        wr(pfc_pkg::OFF_CTRL, {27'h0, c}, r);
        check(r, pfc_pkg::BRESP_OKAY);
        n = 0;
        do begin
            rd(pfc_pkg::OFF_STATUS, o);
            n++;
        end while (o[pfc_pkg::ST_BUSY] !== 1'b0 && n < 50);
        check(o[pfc_pkg::ST_DONE], 1'b1);
        rd(pfc_pkg::OFF_RDATA, o);
    endtask : op
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            rd(pfc_pkg::OFF_STATUS, v);
            n++;
        end while (v[pfc_pkg::ST_READY] !== 1'b1 && n < 300);
    endtask : wait_ready
    task automatic close_out();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check(ce_n, 1'b1);
        check(reset_n, 1'b0);
        rd(pfc_pkg::OFF_TIMING, v);
        check(v, {24'h0, pfc_pkg::PHASE_CYC});
        wr(5'h1C, 32'h0, r);
        check(r, pfc_pkg::BRESP_SLVERR);
        rd(5'h1C, v);
        check(v, 32'h0);
        check(rresp, pfc_pkg::BRESP_OKAY);
        // cycles only run once software lifts the flash out of reset
        wr(pfc_pkg::OFF_CTRL, 32'h0C, r);
        check(reset_n, 1'b1);
        foreach (rows[i]) begin
            op(rows[i].c, rows[i].a, rows[i].d, v);
            if (!rows[i].c[pfc_pkg::CTRL_WRITE])
                check(v[15:0] & rows[i].m, rows[i].e);
        end
        rd(pfc_pkg::OFF_STATUS, v);
        check(v[pfc_pkg::ST_READY], 1'b0);
        check(v[pfc_pkg::ST_POLL7], 1'b1);
        op(5'h0D, 19'h40, 16'h0, v);
        op(5'h0D, 19'h40, 16'h0, v2);
        check(v[6] ^ v2[6], 1'b1);
        wait_ready();
        check(v[pfc_pkg::ST_READY], 1'b1);
        op(5'h0D, 19'h40, 16'h0, v);
        check(v[15:0], 16'h1234);
        // program again, then pull reset in mid-operation
        for (int i = 3; i < 7; i++)
            op(rows[i].c, rows[i].a, rows[i].d, v);
        wr(pfc_pkg::OFF_CTRL, 32'h05, r);
        wait_ready();
        check(v[pfc_pkg::ST_READY], 1'b1);
        check(v[pfc_pkg::ST_BUSY], 1'b0);
        check(reset_n, 1'b0);
        wr(pfc_pkg::OFF_CTRL, 32'h18, r);
        rd(pfc_pkg::OFF_CTRL, v);
        check(v, 32'h18);
        check(hv, 1'b1);
        op(5'h0D, 19'h40, 16'h0, v);
        check(v[15:0], 16'h1234);
        close_out();
    end
    // a hang counts as a failure
    initial begin
        #200000;
        failures++;
        close_out();
    end
endmodule : testbench

/* File: verilog/pfc_ctrl.sv */
/*
 * pfc_ctrl: host-side controller for a parallel NOR flash.
 * Software writes address, data and a command word over AXI4-Lite; the
 * controller runs one read or one write bus cycle on the flash pins, and
 * reports the ready/busy pin and the polled status bits.
 * Assumes: flash pins are asynchronous; the bench resolves the data bus
 * from the output enables (enable low = this end drives).
 */
// Summary of operation
// R1 - width select low means byte mode, high means 16-bit word mode
// R2 - word mode: 18 address lines, 16-bit data on all data pins
// R3 - byte mode: top data pin is address LSB, data on low eight pins
// R4 - byte mode: device leaves data pins 14..8 unused and floating
// R5 - chip select high floats the bus and puts device in standby
// R6 - host drives output enable low to read, holds it high when writing
// R7 - output enable high makes the device float its data pins
// R8 - write happens when write strobe low, chip select low, output enable high
// R9 - asserted reset aborts program or erase, back to read-array
// R10 - during reset the device floats the bus and ignores commands
// R11 - ready/busy is low during embedded operations, high when ready
// R12 - host trusts ready/busy only after the last write strobe rises; ready_seen is taken every cycle regardless
// R13 - program is a four-cycle command run internally by the device
// R14 - erase preprograms, then times and verifies erase pulses
// R15 - one erase may hit any sector set or the whole chip
// R16 - sector erase can be suspended indefinitely, then resumed
// R17 - device latches command address and data during write cycles
// R18 - during embedded operation reads give data-polling and toggle bits
// R19 - low-supply detector blocks writes during power ramps
// R20 - protected sectors refuse program and erase
// R21 - high voltage on reset pin temporarily unprotects sectors
// R22 - eleven sectors with small boot sectors at top or bottom
// R23 - a sector is the smallest erasable and protectable unit
// R24 - device defaults to read-array after power-up and operations
`timescale 1ns/1ps
module pfc_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AXI4-Lite slave
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // flash pins
    output logic [17:0]      fl_addr,
    output logic [15:0]      fl_dq_o,
    output logic [15:0]      fl_dq_oe_n,
    input  wire logic [15:0] fl_dq_i,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n,
    output logic             fl_byte_n,
    output logic             fl_reset_n,
    output logic             fl_reset_hv,
    input  wire logic        op_done_flag
);
    // setup, strobe and hold each last one phase; idle keeps the bus free
    typedef enum {
        PFC_IDLE, PFC_SETUP, PFC_STROBE, PFC_HOLD
    } pfc_state_type;

    typedef struct packed {
        // flash cycle sequencer
        pfc_state_type state;
        logic [7:0]    cnt;
        logic [7:0]    phase;
        // software-visible control and status
        logic          is_write;
        logic          word;
        logic          reset_pin;
        logic          hv;
        logic [18:0]   addr;
        logic [15:0]   wdata;
        logic [15:0]   rdata;
        logic          done;
        logic          ready_seen;
        // write and read channel holding
        logic [4:0]    aw_addr;
        logic          aw_have;
        logic [31:0]   w_data;
        logic          w_have;
        logic [1:0]    bresp;
        logic          bvalid;
        logic [31:0]   r_data;
        logic          rvalid;
        // registered pin drive
        logic [17:0]   pa;
        logic [15:0]   pdo;
        logic [15:0]   poe_n;
        logic          ce_n;
        logic          oe_n;
        logic          we_n;
    } pfc_regs_type;

    // all state in one register; r_d is its next value
    pfc_regs_type r_q;
    pfc_regs_type r_d;
    // ready/busy in the top bit, data pins below
    logic [16:0]  pins_sync;

    // ready/busy and data pins are asynchronous to ref_clk
    pfc_sync2 #(.W(17)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({op_done_flag, fl_dq_i}),
        .sync_out (pins_sync)
    );

    // one next-state process: every field but ready_seen holds unless a branch moves it
    always_comb begin
        logic [31:0] wv;
        logic        busy;
        wv   = r_q.w_data;
        busy = (r_q.state != PFC_IDLE);
        r_d  = r_q;
        // accept address and data in either order
        if (!r_q.aw_have && s_axi_awvalid) begin
            r_d.aw_have = 1'b1;
            r_d.aw_addr = s_axi_awaddr;
        end
        if (!r_q.w_have && s_axi_wvalid) begin
            r_d.w_have = 1'b1;
            // lanes whose strobe is low are stored as zero, not merged
            r_d.w_data = s_axi_wdata & {{8{s_axi_wstrb[3]}},
                {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                {8{s_axi_wstrb[0]}}};
        end
        // each answer stands until its ready is seen
        if (r_q.bvalid && s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end
        if (r_q.rvalid && s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end
        // the ready/busy level is taken every cycle, whether or not a strobe rose
        r_d.ready_seen = pins_sync[16]; // [R11] [R12]
        // register write once both halves are held
        // status and read data are read only and answer with an error
        if (r_q.aw_have && r_q.w_have && !r_q.bvalid) begin
            r_d.aw_have = 1'b0;
            r_d.w_have  = 1'b0;
            r_d.bvalid  = 1'b1;
            r_d.bresp   = pfc_pkg::BRESP_OKAY;
            wv = r_q.w_data;
            unique case (r_q.aw_addr)
                pfc_pkg::OFF_CTRL: begin
                    r_d.word      = wv[pfc_pkg::CTRL_WORD];
                    r_d.reset_pin = wv[pfc_pkg::CTRL_RESET];
                    r_d.hv        = wv[pfc_pkg::CTRL_HV]; // [R21]
                    // a new cycle is refused while one runs
                    // go itself is not stored, so it reads back as zero
                    if (wv[pfc_pkg::CTRL_GO] && !busy) begin
                        r_d.is_write = wv[pfc_pkg::CTRL_WRITE];
                        r_d.state    = PFC_SETUP;
                        r_d.cnt      = r_q.phase;
                        r_d.done     = 1'b0;
                    end
                end
                pfc_pkg::OFF_ADDR:   r_d.addr  = wv[18:0];
                pfc_pkg::OFF_WDATA:  r_d.wdata = wv[15:0];
                // a zero phase would wrap the 8-bit count to a 256-cycle phase, so it becomes one
                pfc_pkg::OFF_TIMING: r_d.phase = (wv[7:0] == 8'h00) ?
                                                 8'h01 : wv[7:0];
                default:             r_d.bresp = pfc_pkg::BRESP_SLVERR;
            endcase
        end
        // register read
        // unmapped offsets read as zero; the read channel never errors
        if (s_axi_arvalid && !r_q.rvalid) begin
            r_d.rvalid = 1'b1;
            unique case (s_axi_araddr)
                pfc_pkg::OFF_CTRL: r_d.r_data = {27'h0, r_q.hv,
                    r_q.reset_pin, r_q.word, r_q.is_write, 1'b0};
                pfc_pkg::OFF_ADDR:   r_d.r_data = {13'h0, r_q.addr};
                pfc_pkg::OFF_WDATA:  r_d.r_data = {16'h0, r_q.wdata};
                pfc_pkg::OFF_STATUS: r_d.r_data = {27'h0,
                    r_q.rdata[6], r_q.rdata[7], r_q.done,
                    r_q.ready_seen, busy}; // [R18]
                pfc_pkg::OFF_RDATA:  r_d.r_data = {16'h0, r_q.rdata};
                pfc_pkg::OFF_TIMING: r_d.r_data = {24'h0, r_q.phase};
                default:             r_d.r_data = pfc_pkg::RESP_OKAY;
            endcase
        end
        // flash bus cycle sequencer
        unique case (r_q.state)
            PFC_IDLE: begin
                // chip deselected and data pins released between cycles
                r_d.ce_n  = 1'b1; // [R5] standby between cycles
                r_d.oe_n  = 1'b1;
                r_d.we_n  = 1'b1;
                r_d.poe_n = 16'hFFFF;
            end
            PFC_SETUP: begin
                // ce_n falls one cycle after entry, so the strobes stay
                // high for one cycle less than a phase before the strobe
                r_d.ce_n = 1'b0;
                r_d.oe_n = 1'b1; // [R6] held high for writes
                // [R2] [R3] byte mode: pin 15 carries the address LSB
                r_d.pa   = r_q.word ? r_q.addr[17:0] : r_q.addr[18:1];
                if (r_q.is_write) begin
                    // [R13] [R17] one command cycle, data latched at rise
                    r_d.pdo   = r_q.word ? r_q.wdata :
                                {r_q.addr[0], 7'h00, r_q.wdata[7:0]};
                    r_d.poe_n = r_q.word ? 16'h0000 : 16'h7F00; // [R4]
                end else begin
                    // reads release the data pins so the flash can drive
                    r_d.pdo   = {r_q.addr[0], 15'h0000};
                    r_d.poe_n = r_q.word ? 16'hFFFF : 16'h7FFF;
                end
                r_d.cnt = r_q.cnt - 8'h01;
                if (r_q.cnt == 8'h01) begin
                    r_d.state = PFC_STROBE;
                    r_d.cnt   = r_q.phase;
                    r_d.we_n  = !r_q.is_write; // [R8]
                    r_d.oe_n  = r_q.is_write;  // [R6] low only to read
                end
            end
            PFC_STROBE: begin
                r_d.cnt = r_q.cnt - 8'h01;
                if (r_q.cnt == 8'h01) begin
                    r_d.state = PFC_HOLD;
                    r_d.cnt   = r_q.phase;
                    r_d.we_n  = 1'b1;
                    r_d.oe_n  = 1'b1;
                    // sampled data has passed the synchroniser
                    // the sample is two flops old: phases under three
                    // cycles would read pins that had not yet settled
                    r_d.rdata = r_q.word ? pins_sync[15:0] :
                                {8'h00, pins_sync[7:0]};
                end
            end
            PFC_HOLD: begin
                // address and data stay driven through hold, so the flash
                // latches them at the rising strobe with margin
                r_d.cnt = r_q.cnt - 8'h01;
                if (r_q.cnt == 8'h01) begin
                    r_d.state = PFC_IDLE;
                    r_d.ce_n  = 1'b1;
                    r_d.poe_n = 16'hFFFF;
                    r_d.done  = 1'b1;
                end
            end
        endcase
        // a cleared reset bit acts at the very edge that lowers the pin,
        // so the chip is never selected while the flash is held in reset
        // holding the reset pin low cuts any cycle short [R9] [R10]
        if (!r_q.reset_pin || !r_d.reset_pin) begin
            r_d.state = PFC_IDLE;
            r_d.ce_n  = 1'b1;
            r_d.oe_n  = 1'b1;
            r_d.we_n  = 1'b1;
            r_d.poe_n = 16'hFFFF;
        end
    end

    // the flash starts held in reset, in word mode, at the default phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_q           <= '0;
            r_q.state     <= PFC_IDLE;
            r_q.phase     <= pfc_pkg::PHASE_CYC;
            r_q.word      <= 1'b1;
            r_q.poe_n     <= 16'hFFFF;
            r_q.ce_n      <= 1'b1;
            r_q.oe_n      <= 1'b1;
            r_q.we_n      <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // every pin and channel output but s_axi_rresp is taken from the state register
    assign s_axi_awready = !r_q.aw_have;
    assign s_axi_wready  = !r_q.w_have;
    assign s_axi_bresp   = r_q.bresp;
    assign s_axi_bvalid  = r_q.bvalid;
    assign s_axi_arready = !r_q.rvalid;
    assign s_axi_rdata   = r_q.r_data;
    // read responses are always OKAY
    assign s_axi_rresp   = pfc_pkg::BRESP_OKAY;
    assign s_axi_rvalid  = r_q.rvalid;
    assign fl_addr       = r_q.pa;
    assign fl_dq_o       = r_q.pdo;
    assign fl_dq_oe_n    = r_q.poe_n;
    assign fl_ce_n       = r_q.ce_n;
    assign fl_oe_n       = r_q.oe_n;
    assign fl_we_n       = r_q.we_n;
    assign fl_byte_n     = r_q.word;      // [R1]
    assign fl_reset_n    = r_q.reset_pin;
    assign fl_reset_hv   = r_q.hv;
endmodule : pfc_ctrl

/* File: verilog/pfc_pkg.sv */
/*
 * pfc_pkg: constants for the parallel flash controller.
 * Assumes: one 100 MHz clock; software reaches the controller over AXI4-Lite.
 */
package pfc_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_ADDR   = 5'h04;
    localparam logic [4:0] OFF_WDATA  = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0C;
    localparam logic [4:0] OFF_RDATA  = 5'h10;
    localparam logic [4:0] OFF_TIMING = 5'h14;
    // control register fields
    localparam int CTRL_GO    = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_WORD  = 2;
    localparam int CTRL_RESET = 3;
    localparam int CTRL_HV    = 4;
    // status register fields
    localparam int ST_BUSY    = 0;
    localparam int ST_READY   = 1;
    localparam int ST_DONE    = 2;
    localparam int ST_POLL7   = 3;
    localparam int ST_TOGGLE6 = 4;
    // flash pin widths
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int DQ_HI  = 15;
    // strobe timing: clock in MHz, default phase length in ns, cycles per phase
    localparam int        CLK_MHZ      = 100;
    localparam int        PHASE_NS     = 60;
    localparam logic [7:0] PHASE_CYC   =
        8'((PHASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [31:0] RESP_OKAY   = 32'h0000_0000;
    localparam logic [1:0]  BRESP_OKAY  = 2'h0;
    localparam logic [1:0]  BRESP_SLVERR = 2'h2;
endpackage : pfc_pkg

/* File: verilog/pfc_sync2.sv */
/*
 * pfc_sync2: two-flop synchroniser for a bus of pin inputs.
 * Assumes: inputs are asynchronous to clk; only the second stage is read.
 */
`timescale 1ns/1ps
module pfc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } pfc_sync_type;

    pfc_sync_type s_q;
    pfc_sync_type s_d;

    // first stage only feeds the second
    always_comb begin
        s_d        = s_q;
        s_d.meta   = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;
endmodule : pfc_sync2
